// ==== verilog/cit_pkg.sv ====
/*
 * Shared constants for the instruction timing core: widths, instruction
 * field layout, opcode and ALU function codes, reset values and timing.
 * Assumes a single 25 MHz clock and synchronous program and data memories
 * that answer combinationally within one system clock.
 */
package cit_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths and timing
  localparam int          PC_W            = 12;     // Program address width
  localparam int          DATA_W          = 8;      // Data path width
  localparam int          INSTR_W         = 16;     // Instruction word width
  localparam int          STACK_DEPTH     = 8;      // Return stack entries
  localparam int          SP_W            = 3;      // Stack pointer width
  localparam int          CLK_PERIOD_NS   = 40;     // System clock period
  localparam int          CLKS_PER_INSTR  = 4;      // Clocks per instr cycle
  localparam int          PHASE_W         = 2;      // Phase counter width
  localparam logic [1:0]  PHASE_EXEC      = 2'(CLKS_PER_INSTR - 2); // Execute
  localparam logic [1:0]  PHASE_LAST      = 2'(CLKS_PER_INSTR - 1); // Fetch

  ////////////////////////////////////////////////////////////////////////
  // Reset values and special addresses
  localparam logic [11:0] RESET_VECTOR    = 12'h000;  // First fetch address
  localparam logic [7:0]  PCL_ADDR        = 8'h06;    // Counter low byte slot
  localparam logic [11:0] PC_ONE          = 12'h001;  // Sequential step

  ////////////////////////////////////////////////////////////////////////
  // Instruction field positions
  localparam int          OP_HI           = 15;     // Opcode top bit
  localparam int          OP_LO           = 12;     // Opcode bottom bit
  localparam int          SUB_HI          = 11;     // Sub-field top bit
  localparam int          SUB_LO          = 8;      // Sub-field bottom bit
  localparam int          POL_BIT         = 11;     // Set / polarity bit
  localparam int          BSEL_HI         = 10;     // Bit select top
  localparam int          BSEL_LO         = 8;      // Bit select bottom
  localparam int          OPR_HI          = 7;      // Operand top bit
  localparam int          OPR_LO          = 0;      // Operand bottom bit

  ////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [3:0]  OP_MISC         = 4'h0;   // Nop, halt, returns
  localparam logic [3:0]  OP_ALU_ACC      = 4'h4;   // Acc <= f(acc, [m])
  localparam logic [3:0]  OP_ALU_MEM      = 4'h5;   // [m] <= f(acc, [m])
  localparam logic [3:0]  OP_ALU_IMM      = 4'h6;   // Acc <= f(acc, x)
  localparam logic [3:0]  OP_BIT          = 4'h7;   // Bit set / clear
  localparam logic [3:0]  OP_SKIP_BIT     = 4'h8;   // Skip on bit test
  localparam logic [3:0]  OP_SKIP_BYTE    = 4'h9;   // Skip on byte test
  localparam logic [3:0]  OP_BRANCH       = 4'hA;   // Unconditional branch
  localparam logic [3:0]  OP_CALL         = 4'hB;   // Subroutine call
  localparam logic [3:0]  OP_TABLE        = 4'hC;   // Table read

  // Sub-codes of OP_MISC
  localparam logic [3:0]  MISC_NOP        = 4'h0;   // No operation
  localparam logic [3:0]  MISC_HALT       = 4'h1;   // Enter power down
  localparam logic [3:0]  MISC_ROUTINE_EXIT   = 4'h2; // Plain return
  localparam logic [3:0]  MISC_INTERRUPT_EXIT = 4'h3; // Return, irq on

  ////////////////////////////////////////////////////////////////////////
  // ALU function codes (instruction sub-field)
  localparam logic [3:0]  FN_ADD          = 4'h0;   // a + b
  localparam logic [3:0]  FN_SUB          = 4'h1;   // a - b
  localparam logic [3:0]  FN_AND          = 4'h2;   // a & b
  localparam logic [3:0]  FN_OR           = 4'h3;   // a | b
  localparam logic [3:0]  FN_XOR          = 4'h4;   // a ^ b
  localparam logic [3:0]  FN_INVERT       = 4'h5;   // ~b
  localparam logic [3:0]  FN_INC          = 4'h6;   // b + 1
  localparam logic [3:0]  FN_DEC          = 4'h7;   // b - 1
  localparam logic [3:0]  FN_RROT         = 4'h8;   // Rotate right plain
  localparam logic [3:0]  FN_LROT         = 4'h9;   // Rotate left plain
  localparam logic [3:0]  FN_RROT_C       = 4'hA;   // Rotate right via carry
  localparam logic [3:0]  FN_LROT_C       = 4'hB;   // Rotate left via carry
  localparam logic [3:0]  FN_PASS_B       = 4'hC;   // Move operand
  localparam logic [3:0]  FN_PASS_A       = 4'hD;   // Move accumulator

endpackage

// ==== verilog/cit_alu.sv ====
/*
 * Eight-bit ALU of the instruction timing core: add, subtract, logic,
 * increment, decrement, rotates and moves, with a carry result and carry and zero update enables.
 * Purely combinational; the caller decides when the outputs are stored.
 */
`timescale 1ns/100ps

module cit_alu (
  input  wire logic [7:0] op_a,      // Accumulator operand
  input  wire logic [7:0] op_b,      // Memory or immediate operand
  input  wire logic [3:0] func,      // Function code
  input  wire logic       carry_in,  // Current carry flag
  output logic      [7:0] result,    // Function result
  output logic            carry_out, // New carry value
  output logic            carry_we,  // Carry flag is updated
  output logic            zero_we    // Zero flag is updated
);

  logic [8:0] wide;                  // Nine-bit sum or difference

  ////////////////////////////////////////////////////////////////////////
  // Function select
  always_comb begin
    wide      = {1'b0, op_b};
    result    = op_b;
    carry_out = carry_in;
    carry_we  = 1'b0;
    zero_we   = 1'b1;
    case (func)
      cit_pkg::FN_ADD: begin                        // Carry past 255
        wide      = {1'b0, op_a} + {1'b0, op_b};
        result    = wide[7:0];
        carry_out = wide[8];
        carry_we  = 1'b1;
      end
      cit_pkg::FN_SUB: begin                        // Borrow below zero
        wide      = {1'b0, op_a} - {1'b0, op_b};
        result    = wide[7:0];
        carry_out = wide[8];
        carry_we  = 1'b1;
      end
      cit_pkg::FN_AND:    result = op_a & op_b;     // Zero flag follows
      cit_pkg::FN_OR:     result = op_a | op_b;
      cit_pkg::FN_XOR:    result = op_a ^ op_b;
      cit_pkg::FN_INVERT: result = ~op_b;
      cit_pkg::FN_INC:    result = op_b + 8'h01;    // Step of one
      cit_pkg::FN_DEC:    result = op_b - 8'h01;
      cit_pkg::FN_RROT: begin                       // End bit wraps
        result  = {op_b[0], op_b[7:1]};
        zero_we = 1'b0;
      end
      cit_pkg::FN_LROT: begin
        result  = {op_b[6:0], op_b[7]};
        zero_we = 1'b0;
      end
      cit_pkg::FN_RROT_C: begin                     // Out bit to carry
        result    = {carry_in, op_b[7:1]};
        carry_out = op_b[0];
        carry_we  = 1'b1;
        zero_we   = 1'b0;
      end
      cit_pkg::FN_LROT_C: begin
        result    = {op_b[6:0], carry_in};
        carry_out = op_b[7];
        carry_we  = 1'b1;
        zero_we   = 1'b0;
      end
      cit_pkg::FN_PASS_B: zero_we = 1'b0;           // Plain move
      cit_pkg::FN_PASS_A: begin
        result  = op_a;
        zero_we = 1'b0;
      end
      default:            zero_we = 1'b0;           // Unused code moves b
    endcase
  end

endmodule

// ==== verilog/cit_core.sv ====
/*
 * Instruction timing core: a four-clock instruction cycle with one word
 * of prefetch, an accumulator data path, a return stack, skips, table
 * reads from program memory and a power-down state.
 * Assumes program and data memories on the same clock that answer
 * combinationally to the registered addresses, and an outside interrupt
 * controller that pulses irq_taken and wake on this clock.
 */
// Functional notes
// - Instruction cycle is four system clocks.
// - One cycle; branch, call, return, table two.
// - Writing counter low byte costs extra cycle.
// - Taken skip two cycles, untaken one.
// - Carry above 255, borrow below zero.
// - Increment, decrement by one, either destination.
// - Logic results of zero set zero flag.
// - Plain rotates wrap end bit around.
// - Carry rotates move leaving bit to carry.
// - Call saves next address; return resumes there.
// - Branch loads target, saves nothing.
// - Skips test byte or bit of memory.
// - Bit set/clear changes only addressed bit.
// - Table read fetches program memory data.
// - Halt enters power-down state.
// - Moves between registers, accumulator, immediates.
// - Interrupt exit sets irq enable; plain keeps.
`timescale 1ns/100ps

module cit_core (
  input  wire logic        ref_clk,                 // System clock
  input  wire logic        rst,                     // Async reset, high
  input  wire logic [15:0] pm_rdata,                // Program memory word
  input  wire logic [7:0]  dm_rdata,                // Data memory byte
  input  wire logic        wake,                    // Leave power down
  input  wire logic        irq_taken,               // Irq accepted, disable
  output logic      [11:0] pm_addr_r,               // Program memory address
  output logic      [7:0]  dm_addr_r,               // Data memory address
  output logic      [7:0]  dm_wdata_r,              // Data memory write data
  output logic             dm_we_r,                 // Data memory write pulse
  output logic      [7:0]  acc_r,                   // Accumulator
  output logic             carry_r,                 // Carry flag
  output logic             zero_r,                  // Zero flag
  output logic             global_irq_enable_r,     // Global irq enable
  output logic      [7:0]  table_high_r,            // Table word high byte
  output logic             halted_r,                // Power-down state
  output logic             instr_cycle_r            // Instruction cycle strobe
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]  phase_r;                             // Clock within cycle
  logic        exec_en;                             // Execute edge enable
  logic        fetch_en;                            // Fetch edge enable
  logic [15:0] ir_r;                                // Instruction register
  logic [11:0] cur_pc_r;                            // Address of ir_r
  logic        ir_valid_r;                          // ir_r may execute
  logic        table_cycle_r;                       // Table fetch cycle
  logic [11:0] resume_r;                            // Address after table
  logic        redirect_r;                          // Flow change pending
  logic        skip_r;                              // Skip pending
  logic        table_req_r;                         // Table read pending
  logic [11:0] target_r;                            // Pending target
  logic [11:0] table_addr_r;                        // Pending table address
  logic [11:0] stack_mem [cit_pkg::STACK_DEPTH];    // Return stack
  logic [2:0]  sp_r;                                // Next free slot
  logic        exec_ok;                             // Instruction executes
  logic [3:0]  opcode;                              // Decoded opcode
  logic [3:0]  sub;                                 // Decoded sub-field
  logic [7:0]  operand;                             // Memory operand
  logic [7:0]  bit_mask;                            // Bit select mask
  logic        bit_val;                             // Selected bit value
  logic [7:0]  alu_b;                               // ALU second operand
  logic [3:0]  alu_fn;                              // ALU function
  logic [7:0]  alu_res;                             // ALU result
  logic        alu_c;                               // ALU carry
  logic        alu_cwe;                             // ALU carry update
  logic        alu_zwe;                             // ALU zero update
  logic        acc_we;                              // Write accumulator
  logic        mem_we;                              // Write data memory
  logic [7:0]  wr_data;                             // Memory write value
  logic        pcl_hit;                             // Operand is counter low

  ////////////////////////////////////////////////////////////////////////
  // Cycle divider: one fetch and one execute enable per four clocks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;                    // Wraps after four
    end
  end

  assign exec_en  = (phase_r == cit_pkg::PHASE_EXEC);
  assign fetch_en = (phase_r == cit_pkg::PHASE_LAST);

  // Strobe marking the fetch edge of every instruction cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      instr_cycle_r <= 1'b0;
    end else begin
      instr_cycle_r <= (phase_r == cit_pkg::PHASE_EXEC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode and operand selection
  assign opcode   = ir_r[cit_pkg::OP_HI:cit_pkg::OP_LO];
  assign sub      = ir_r[cit_pkg::SUB_HI:cit_pkg::SUB_LO];
  assign pcl_hit  = (dm_addr_r == cit_pkg::PCL_ADDR);
  assign operand  = pcl_hit ? cur_pc_r[7:0] : dm_rdata;   // Counter reads back
  assign bit_mask = 8'h01 << ir_r[cit_pkg::BSEL_HI:cit_pkg::BSEL_LO];
  assign bit_val  = |(operand & bit_mask);
  assign exec_ok  = exec_en && ir_valid_r && !table_cycle_r && !halted_r;

  // Per-opcode control
  always_comb begin
    alu_b   = operand;
    alu_fn  = sub;
    acc_we  = 1'b0;
    mem_we  = 1'b0;
    wr_data = alu_res;
    case (opcode)
      cit_pkg::OP_ALU_ACC: acc_we = 1'b1;           // Result to acc
      cit_pkg::OP_ALU_MEM: mem_we = 1'b1;           // Result in place
      cit_pkg::OP_ALU_IMM: begin                    // Immediate operand
        alu_b  = ir_r[cit_pkg::OPR_HI:cit_pkg::OPR_LO];
        acc_we = 1'b1;
      end
      cit_pkg::OP_BIT: begin                        // One bit only
        mem_we  = 1'b1;
        wr_data = ir_r[cit_pkg::POL_BIT] ? (operand | bit_mask)
                                         : (operand & ~bit_mask);
      end
      default: alu_fn = cit_pkg::FN_PASS_B;         // No data path use
    endcase
  end

  cit_alu u_alu (
    .op_a      (acc_r),
    .op_b      (alu_b),
    .func      (alu_fn),
    .carry_in  (carry_r),
    .result    (alu_res),
    .carry_out (alu_c),
    .carry_we  (alu_cwe),
    .zero_we   (alu_zwe)
  );

  ////////////////////////////////////////////////////////////////////////
  // Accumulator: ALU results and the low byte of a table word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_r <= 8'h00;
    end else if (exec_ok && acc_we) begin
      acc_r <= alu_res;
    end else if (fetch_en && table_cycle_r) begin
      acc_r <= pm_rdata[7:0];                       // Table data
    end
  end

  // High byte of a table word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      table_high_r <= 8'h00;
    end else if (fetch_en && table_cycle_r) begin
      table_high_r <= pm_rdata[15:8];
    end
  end

  // Carry and zero flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      carry_r <= 1'b0;
      zero_r  <= 1'b0;
    end else if (exec_ok && (acc_we || (mem_we && opcode != cit_pkg::OP_BIT))) begin
      if (alu_cwe) begin
        carry_r <= alu_c;
      end
      if (alu_zwe) begin
        zero_r <= (alu_res == 8'h00);
      end
    end
  end

  // Data memory write, one clock wide before the next fetch edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dm_we_r    <= 1'b0;
      dm_wdata_r <= 8'h00;
    end else begin
      dm_we_r <= exec_ok && mem_we && !pcl_hit;     // Counter slot is internal
      if (exec_ok && mem_we) begin
        dm_wdata_r <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flow decisions taken at the execute edge, consumed at the fetch edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      redirect_r   <= 1'b0;
      skip_r       <= 1'b0;
      table_req_r  <= 1'b0;
      target_r     <= cit_pkg::RESET_VECTOR;
      table_addr_r <= cit_pkg::RESET_VECTOR;
    end else if (fetch_en) begin
      redirect_r  <= 1'b0;
      skip_r      <= 1'b0;
      table_req_r <= 1'b0;
    end else if (exec_ok) begin
      case (opcode)
        cit_pkg::OP_BRANCH, cit_pkg::OP_CALL: begin
          redirect_r <= 1'b1;
          target_r   <= ir_r[11:0];
        end
        cit_pkg::OP_MISC: begin
          if (sub == cit_pkg::MISC_ROUTINE_EXIT ||
              sub == cit_pkg::MISC_INTERRUPT_EXIT) begin
            redirect_r <= 1'b1;                       // Saved address
            target_r   <= stack_mem[sp_r - 3'h1];
          end
        end
        cit_pkg::OP_SKIP_BIT:                         // Bit
          skip_r <= (bit_val == ir_r[cit_pkg::POL_BIT]);
        cit_pkg::OP_SKIP_BYTE:                        // Byte
          skip_r <= ((operand != 8'h00) == ir_r[cit_pkg::POL_BIT]);
        cit_pkg::OP_TABLE: begin
          table_req_r  <= 1'b1;
          table_addr_r <= {ir_r[cit_pkg::SUB_HI:cit_pkg::SUB_LO], acc_r};
        end
        default: ;
      endcase
      if (mem_we && pcl_hit) begin                    // Counter write jumps
        redirect_r <= 1'b1;
        target_r   <= {cur_pc_r[11:8], wr_data};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetch: prefetch one word, drop it on flow changes and skips
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pm_addr_r     <= cit_pkg::RESET_VECTOR;
      ir_r          <= 16'h0000;
      cur_pc_r      <= cit_pkg::RESET_VECTOR;
      dm_addr_r     <= 8'h00;
      ir_valid_r    <= 1'b0;
      table_cycle_r <= 1'b0;
      resume_r      <= cit_pkg::RESET_VECTOR;
    end else if (fetch_en) begin
      if (table_cycle_r) begin                        // Held word runs next
        table_cycle_r <= 1'b0;
        ir_valid_r    <= 1'b1;
        pm_addr_r     <= resume_r;
      end else if (table_req_r) begin                 // Hold next word
        ir_r          <= pm_rdata;
        cur_pc_r      <= pm_addr_r;
        dm_addr_r     <= pm_rdata[cit_pkg::OPR_HI:cit_pkg::OPR_LO];
        ir_valid_r    <= 1'b0;
        table_cycle_r <= 1'b1;
        pm_addr_r     <= table_addr_r;
        resume_r      <= pm_addr_r + cit_pkg::PC_ONE;
      end else if (redirect_r) begin                  // Drop prefetch
        ir_valid_r <= 1'b0;
        pm_addr_r  <= target_r;
      end else if (skip_r) begin                      // Drop skipped word
        ir_valid_r <= 1'b0;
        pm_addr_r  <= pm_addr_r + cit_pkg::PC_ONE;
      end else if (halted_r) begin                    // Frozen while down
        ir_valid_r <= 1'b0;
      end else begin                                  // Sequential
        ir_r       <= pm_rdata;
        cur_pc_r   <= pm_addr_r;
        dm_addr_r  <= pm_rdata[cit_pkg::OPR_HI:cit_pkg::OPR_LO];
        ir_valid_r <= 1'b1;
        pm_addr_r  <= pm_addr_r + cit_pkg::PC_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Return stack: push address after the call, pop on either return
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_r <= 3'h0;
    end else if (exec_ok) begin
      if (opcode == cit_pkg::OP_CALL) begin
        stack_mem[sp_r] <= pm_addr_r;                 // Next address
        sp_r            <= sp_r + 3'h1;
      end else if (opcode == cit_pkg::OP_MISC &&
                   (sub == cit_pkg::MISC_ROUTINE_EXIT ||
                    sub == cit_pkg::MISC_INTERRUPT_EXIT)) begin
        sp_r <= sp_r - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Global interrupt enable: set by interrupt exit, cleared on acceptance
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      global_irq_enable_r <= 1'b0;
    end else if (exec_ok && opcode == cit_pkg::OP_MISC &&
                 sub == cit_pkg::MISC_INTERRUPT_EXIT) begin
      global_irq_enable_r <= 1'b1;                    // Set wins over clear
    end else if (irq_taken) begin
      global_irq_enable_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-down state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halted_r <= 1'b0;
    end else if (exec_ok && opcode == cit_pkg::OP_MISC &&
                 sub == cit_pkg::MISC_HALT) begin
      halted_r <= 1'b1;
    end else if (wake) begin
      halted_r <= 1'b0;
    end
  end

endmodule

// ==== tb/cit_core_checker.sv ====
/* Port-level timing checks for cit_core.
   Assumes binding into cit_core; single clock, async high reset. */
`timescale 1ns/100ps
module cit_core_checker (
  input wire logic        ref_clk,             // Clock
  input wire logic        rst,                 // Reset
  input wire logic        wake,                // Wake request
  input wire logic        irq_taken,           // Irq accepted
  input wire logic [11:0] pm_addr_r,           // Fetch address
  input wire logic [7:0]  dm_addr_r,           // Operand address
  input wire logic        dm_we_r,             // Write pulse
  input wire logic [7:0]  acc_r,               // Accumulator
  input wire logic        global_irq_enable_r, // Irq enable
  input wire logic        halted_r,            // Power down
  input wire logic        instr_cycle_r        // Cycle strobe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  a_cycle_four_clk: assert property (instr_cycle_r && !halted_r |=>
    !instr_cycle_r [*3] ##1 instr_cycle_r) else $error("strobe spacing wrong");
  a_we_single: assert property (dm_we_r |-> instr_cycle_r ##1 !dm_we_r [*3])
    else $error("write pulse misplaced");
  a_we_not_pcl: assert property (dm_we_r |-> dm_addr_r != cit_pkg::PCL_ADDR)
    else $error("counter byte written out");
  a_acc_at_exec: assert property ($changed(acc_r) |->
    instr_cycle_r || $past(instr_cycle_r)) else $error("acc changed off execute");
  a_addr_at_fetch: assert property ($changed(dm_addr_r) |-> $past(instr_cycle_r))
    else $error("operand address off fetch");
  a_halt_frozen: assert property (halted_r && $past(halted_r, 2) && !wake |=>
    $stable(pm_addr_r) && $stable(acc_r)) else $error("core ran while halted");
  a_wake_clears: assert property (wake |=> !halted_r) else $error("wake ignored");
  a_irq_clear: assert property (irq_taken |=> !global_irq_enable_r || instr_cycle_r)
    else $error("irq enable not cleared");
  // Main scenarios reached
  c_write: cover property (dm_we_r);
  c_halt: cover property ($rose(halted_r));
  c_irq_on: cover property ($rose(global_irq_enable_r));
endmodule

// ==== tb/cit_core_bench.sv ====
/* Self-checking bench for cit_core: program and data stores, programs.
   Assumes cit_pkg encodings and the checker file compiled before. */
`timescale 1ns/100ps
module cit_core_bench;
  logic        ref_clk = 0, rst = 1, wake = 0, irq_taken = 0; // Drives
  logic [15:0] pm [4096];                                      // Program store
  logic [7:0]  dm [256];                                       // Data store
  logic [11:0] pa;                                             // Fetch address
  logic [7:0]  da, dw, acc, th, a, b;                          // Core outputs, operands
  logic        we, c, z, ie, hl, ic;                           // Core flags
  logic [9:0]  e;                                              // Expected carry, zero, value
  logic [31:0] sd = 32'h9C872888;                              // Random state
  int          errors = 0, num_checks = 0, kh, k;              // Counters
  // Flow programs: branch, return, skips, counter write, table, interrupt exit
  logic [15:0] prg [8][6] = '{'{16'hA003, 16'h6C55, 16'h6C55, 16'h0100, 16'h0, 16'h0},
    '{16'hB004, 16'h6C77, 16'h0100, 16'h0, 16'h6C11, 16'h0200},
    '{16'h8010, 16'h6C55, 16'h0100, 16'h0, 16'h0, 16'h0},
    '{16'h8010, 16'h6C55, 16'h0100, 16'h0, 16'h0, 16'h0},
    '{16'h6C03, 16'h5D06, 16'h6C55, 16'h0100, 16'h0, 16'h0},
    '{16'h6C04, 16'hC000, 16'h0100, 16'h0, 16'hABCD, 16'h0},
    '{16'h9810, 16'h6C55, 16'h0100, 16'h0, 16'h0, 16'h0},
    '{16'hB004, 16'h6C77, 16'h0100, 16'h0, 16'h6C11, 16'h0300}};
  int          cyc [8] = '{2, 6, 2, 2, 3, 3, 2, 6};            // Cycles before halt
  logic [7:0]  ea [8] = '{8'h00, 8'h77, 8'h00, 8'h55, 8'h03, 8'hCD, 8'h00, 8'h77};
  logic [7:0]  d10 [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h5A, 8'h00};
  ////////////////////////////////////////////////////////////////////////
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (we) dm[da] <= dw;
  cit_core i_dut (.ref_clk, .rst, .pm_rdata(pm[pa]), .dm_rdata(dm[da]), .wake, .irq_taken,
    .pm_addr_r(pa), .dm_addr_r(da), .dm_wdata_r(dw), .dm_we_r(we), .acc_r(acc),
    .carry_r(c), .zero_r(z), .global_irq_enable_r(ie), .table_high_r(th), .halted_r(hl),
    .instr_cycle_r(ic));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Expected {carry, zero, result} with carry in zero
  function automatic logic [9:0] alu(input logic [3:0] f, input logic [7:0] x, y);
    logic [8:0] t [14];
    t = '{x + y, x - y, x & y, x | y, x ^ y, ~y, y + 1, y - 1, {y[0], y[7:1]},
      {y[6:0], y[7]}, {1'b0, y[7:1]}, {y[6:0], 1'b0}, y, x};
    return {f < 2 ? t[f][8] : f == 4'hA ? y[0] : f == 4'hB & y[7], f < 8 && t[f][7:0] == 0,
      t[f][7:0]};
  endfunction
  task automatic chk(input logic [31:0] g, ex);
    num_checks++;
    if (g !== ex) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, g, ex);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset, then count strobes until power down
  task automatic run(output int n);
    rst = 1;
    repeat (16) @(negedge ref_clk);
    rst = 0;
    n = 0;
    for (int t = 0; t < 400 && hl !== 1'b1; t++) begin
      @(negedge ref_clk);
      n += ic;
    end
  endtask
  initial begin
    #1_000_000;
    errors++;
    final_report;
  end
  initial begin
    foreach (pm[i]) pm[i] = 16'h0;
    foreach (dm[i]) dm[i] = 8'h00;
    pm[0] = 16'h0100;
    pm[2] = 16'h0100;                                          // Halt after ALU pair
    run(kh);
    for (int j = 0; j < 44; j++) begin
      sd = xs(sd);
      a = j < 2 ? {8{j == 0}} : sd[7:0];
      b = j < 2 ? 8'h01 : sd[15:8];
      dm[8'h10] = b;
      pm[0] = {8'h6C, a};
      pm[1] = j < 28 ? {3'b010, sd[16], 4'(j % 14), 8'h10} : {4'h7, sd[19:16], 8'h10};
      run(k);
      chk(k, kh + 2);
      e = alu(4'(j % 14), a, b);
      if (j >= 28) chk(dm[8'h10], sd[19] ? b | 8'(1 << sd[18:16]) : b & ~8'(1 << sd[18:16]));
      else chk({c, z, acc}, sd[16] ? {e[9:8], a} : e);
      if (j < 28 && sd[16]) chk(dm[8'h10], e[7:0]);
    end
    for (int i = 0; i < 8; i++) begin
      for (int w = 0; w < 6; w++) pm[w] = prg[i][w];
      dm[8'h10] = d10[i];
      run(k);
      chk(k, kh + cyc[i]);
      chk({th, ie, acc}, {i == 5 ? 8'hAB : 8'h00, i == 7, ea[i]});
    end
    @(negedge ref_clk);
    irq_taken = 1;
    @(negedge ref_clk);
    irq_taken = 0;
    repeat (8) @(negedge ref_clk);
    chk({hl, pa}, {1'b1, 12'h003});
    wake = 1;
    @(negedge ref_clk);
    wake = 0;
    chk({ie, hl}, 2'b00);
    final_report;
  end
endmodule
bind cit_core cit_core_checker i_chk (.ref_clk, .rst, .wake, .irq_taken, .pm_addr_r, .dm_addr_r,
  .dm_we_r, .acc_r, .global_irq_enable_r, .halted_r, .instr_cycle_r);
